/* File: core/voltage_reference_params.svh */
// register offsets, field positions and timing counts for the voltage reference control block
`ifndef VOLTAGE_REFERENCE_PARAMS_SVH
`define VOLTAGE_REFERENCE_PARAMS_SVH
// register indices (printed offsets) and byte addresses
`define VR_TRIM_INDEX 4'h0
`define VR_CTRL_INDEX 4'h1
`define VR_TRIM_ADDR 6'h00
`define VR_CTRL_ADDR 6'h04
`define VR_ADDR_W 6
// field positions
`define VR_TRIM_CHOP_BIT 6
`define VR_CTRL_EN_BIT 7
`define VR_CTRL_REG_BIT 6
`define VR_CTRL_COMP_BIT 5
`define VR_CTRL_STABLE_BIT 2
// reset value of the control register
`define VR_CTRL_RESET 8'h00
// bandgap startup time in ns and derived cycle count at 50 ns period
`define VR_CLK_PERIOD_NS 50
`define VR_STARTUP_NS 20000
`define VR_STARTUP_CYCLES ((`VR_STARTUP_NS + `VR_CLK_PERIOD_NS - 1) / `VR_CLK_PERIOD_NS)
// software wait between chop-on and regulator-on, kept strictly above 300 ns
`define VR_REG_SETTLE_NS 300
`define VR_REG_SETTLE_CYCLES (`VR_REG_SETTLE_NS / `VR_CLK_PERIOD_NS + 1)
// axi response codes
`define VR_RESP_OKAY 2'b00
`define VR_RESP_SLVERR 2'b10
`endif

/* File: core/voltage_reference_pkg.sv */
// types for the voltage reference control block
package voltage_reference_pkg;
    // buffer mode field encodings
    typedef enum logic [1:0] {
        MODE_BANDGAP_ONLY = 2'b00,
        MODE_HIGH_POWER = 2'b01,
        MODE_LOW_POWER = 2'b10,
        MODE_RESERVED = 2'b11
    } buffer_mode_select_t;
    // enables toward the analog block
    typedef struct packed {
        logic bandgap_enable;
        logic regulator_enable;
        logic curvature_comp_enable;
        logic chop_oscillator_enable;
        logic high_power_buffer_enable;
        logic low_power_buffer_enable;
        logic [5:0] trim_code;
    } analog_ctrl_t;
    // startup tracker states
    typedef enum logic [1:0] {
        ST_OFF,
        ST_STARTING,
        ST_STABLE
    } startup_state_t;
endpackage

/* File: core/voltage_reference_control.sv */
// voltage reference control logic with an axi4-lite register slave
//
// Behaviour
// [R1] trim at 0x0, control at 0x1
// [R2] control register resets to zero
// [R3] trim loaded from factory value at reset
// [R4] trim bits 5..0 hold trim code
// [R5] trim bit 6 drives chop enable
// [R6] software keeps chop on with regulator
// [R7] control bit 7 enables whole reference (chop enable follows trim bit 6 only)
// [R8] bus clock gating never disables reference
// [R9] control bit 6 enables regulator
// [R10] control bit 5 enables curvature compensation
// [R11] control bits 4..3 read zero, ignore writes
// [R12] control bit 2 is read-only stable flag
// [R13] software trusts stable flag only unchopped
// [R14] control bits 1..0 select buffer mode
// [R15] output pin high impedance when buffer off
// [R16] output driven when enabled with buffer mode
// [R17] software sets chop, regulator, compensation
// [R18] configuration kept in all power modes
// [R19] software sequences regulator enable after chop
// [R20] mode change keeps stable flag set
// [R21] writes take effect at completing edge
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "voltage_reference_params.svh"

module voltage_reference_control
    import voltage_reference_pkg::*;
#(
    // startup time count, shortened in simulation
    parameter int STARTUP_CYCLES = `VR_STARTUP_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // factory trim value presented by fuse logic
    input wire logic [7:0] factory_trim,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [`VR_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [`VR_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // analog block controls
    output analog_ctrl_t analog_ctrl,
    // reference output pin buffer enable
    output logic ref_out_oe
);

    // =====================================================================
    // registers
    // =====================================================================
    logic [7:0] reference_trim; // trim register contents
    logic reference_enable; // control bit 7
    logic regulator_enable; // control bit 6
    logic curvature_comp_enable; // control bit 5
    buffer_mode_select_t buffer_mode_select; // control bits 1..0
    logic reference_stable_flag; // control bit 2, hardware owned
    logic trim_loaded; // factory value captured after reset
    startup_state_t startup_state; // bandgap startup tracker
    logic [$clog2(STARTUP_CYCLES+1)-1:0] startup_count; // startup timer

    // =====================================================================
    // write channel
    // =====================================================================
    logic aw_held; // address captured, waiting for data
    logic w_held; // data captured, waiting for address
    logic [`VR_ADDR_W-1:0] aw_addr_q; // captured write address
    logic [31:0] w_data_q; // captured write data
    logic [3:0] w_strb_q; // captured strobes
    logic do_write; // both halves present this cycle
    logic [`VR_ADDR_W-1:0] wr_addr; // effective write address
    logic [31:0] wr_data; // effective write data
    logic [3:0] wr_strb; // effective strobes

    // combine captured and live halves so a write completes in one edge
    always_comb begin
        wr_addr = aw_held ? aw_addr_q : awaddr;
        wr_data = w_held ? w_data_q : wdata;
        wr_strb = w_held ? w_strb_q : wstrb;
        do_write = (aw_held || (awvalid && awready)) && (w_held || (wvalid && wready)) && !bvalid;
    end

    // channel handshakes; one write outstanding at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            bvalid <= 1'b0;
            bresp <= `VR_RESP_OKAY;
        end else begin
            // ready offered whenever nothing is held and no response pending
            awready <= !aw_held && !bvalid && !(awvalid && awready) && !do_write;
            wready <= !w_held && !bvalid && !(wvalid && wready) && !do_write;
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                // unmapped words answer with a slave error
                bresp <= (wr_addr == `VR_TRIM_ADDR || wr_addr == `VR_CTRL_ADDR) ?
                    `VR_RESP_OKAY : `VR_RESP_SLVERR;
            end else begin
                if (awvalid && awready) begin
                    aw_held <= 1'b1;
                    aw_addr_q <= awaddr;
                end
                if (wvalid && wready) begin
                    w_held <= 1'b1;
                    w_data_q <= wdata;
                    w_strb_q <= wstrb;
                end
                if (bvalid && bready) begin
                    bvalid <= 1'b0;
                end
            end
        end
    end

    // =====================================================================
    // trim register
    // =====================================================================
    // factory value is sampled by a clocked process after release, never by reset itself
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trim_loaded <= 1'b0;
            reference_trim <= 8'h00;
        end else if (!trim_loaded) begin
            trim_loaded <= 1'b1;
            reference_trim <= factory_trim; // [R3]
        end else if (do_write && wr_addr == `VR_TRIM_ADDR && wr_strb[0]) begin
            reference_trim <= wr_data[7:0]; // [R4] [R5] [R21]
        end
    end

    // =====================================================================
    // control register
    // =====================================================================
    // bits 4..3 and 2 are never stored from the bus
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reference_enable <= 1'(`VR_CTRL_RESET >> `VR_CTRL_EN_BIT); // [R2]
            regulator_enable <= 1'b0;
            curvature_comp_enable <= 1'b0;
            buffer_mode_select <= MODE_BANDGAP_ONLY;
        end else if (do_write && wr_addr == `VR_CTRL_ADDR && wr_strb[0]) begin
            reference_enable <= wr_data[`VR_CTRL_EN_BIT]; // [R7] [R21]
            regulator_enable <= wr_data[`VR_CTRL_REG_BIT]; // [R9]
            curvature_comp_enable <= wr_data[`VR_CTRL_COMP_BIT]; // [R10]
            buffer_mode_select <= buffer_mode_select_t'(wr_data[1:0]); // [R14] [R11]
        end
    end

    // =====================================================================
    // bandgap startup tracking
    // =====================================================================
    // a timer stands in for the analog settling detector; mode changes do not restart it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            startup_state <= ST_OFF;
            startup_count <= '0;
            reference_stable_flag <= 1'b0;
        end else begin
            case (startup_state)
                ST_OFF: begin
                    reference_stable_flag <= 1'b0;
                    startup_count <= '0;
                    if (reference_enable) begin
                        startup_state <= ST_STARTING;
                    end
                end
                ST_STARTING: begin
                    if (!reference_enable) begin
                        startup_state <= ST_OFF;
                    end else if (startup_count == ($bits(startup_count))'(STARTUP_CYCLES - 1)) begin
                        startup_state <= ST_STABLE;
                        reference_stable_flag <= 1'b1; // [R12]
                    end else begin
                        startup_count <= startup_count + 1'b1;
                    end
                end
                ST_STABLE: begin
                    // only disabling clears it, buffer mode is ignored here
                    if (!reference_enable) begin
                        startup_state <= ST_OFF;
                        reference_stable_flag <= 1'b0; // [R12] [R20]
                    end
                end
                default: begin
                    startup_state <= ST_OFF;
                end
            endcase
        end
    end

    // =====================================================================
    // analog controls and output pin
    // =====================================================================
    // enables come from stored bits only; no clock or power-mode gating, so the
    // configuration survives low-power modes and bus clock gating [R8] [R18]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog_ctrl <= '0;
            ref_out_oe <= 1'b0;
        end else begin
            analog_ctrl.bandgap_enable <= reference_enable; // [R7]
            analog_ctrl.regulator_enable <= reference_enable && regulator_enable; // [R9]
            analog_ctrl.curvature_comp_enable <= reference_enable && curvature_comp_enable; // [R10]
            analog_ctrl.chop_oscillator_enable <= reference_trim[`VR_TRIM_CHOP_BIT]; // [R5]
            analog_ctrl.high_power_buffer_enable <= reference_enable && buffer_mode_select == MODE_HIGH_POWER;
            analog_ctrl.low_power_buffer_enable <= reference_enable && buffer_mode_select == MODE_LOW_POWER;
            analog_ctrl.trim_code <= reference_trim[5:0]; // [R4]
            // reserved mode keeps the pin released as well
            ref_out_oe <= reference_enable && (buffer_mode_select == MODE_HIGH_POWER ||
                buffer_mode_select == MODE_LOW_POWER); // [R15] [R16]
        end
    end

    // =====================================================================
    // read channel
    // =====================================================================
    // reads have no side effects; one read outstanding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `VR_RESP_OKAY;
        end else begin
            arready <= !rvalid && !(arvalid && arready);
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp <= `VR_RESP_OKAY;
                case (araddr)
                    `VR_TRIM_ADDR: rdata <= {24'h00_0000, reference_trim}; // [R1]
                    `VR_CTRL_ADDR: rdata <= {24'h00_0000, reference_enable, regulator_enable,
                        curvature_comp_enable, 2'b00, reference_stable_flag, buffer_mode_select}; // [R1] [R11]
                    default: begin
                        rdata <= 32'h0000_0000;
                        rresp <= `VR_RESP_SLVERR;
                    end
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // =====================================================================
    // checks
    // =====================================================================
    AST_OE_FOLLOWS_MODE: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
        ##1 ref_out_oe == $past(reference_enable && (buffer_mode_select == MODE_HIGH_POWER
        || buffer_mode_select == MODE_LOW_POWER)))
        else $error("output enable does not follow mode");
    AST_OE_ON: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
        (reference_enable && buffer_mode_select == MODE_LOW_POWER) |=> ref_out_oe)
        else $error("output not driven in buffer mode");
    AST_CHOP_FOLLOWS: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
        reference_trim[`VR_TRIM_CHOP_BIT] |=> analog_ctrl.chop_oscillator_enable)
        else $error("chop enable not driven");
    AST_STABLE_NEEDS_EN: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
        !reference_enable |=> !reference_stable_flag)
        else $error("stable flag while disabled");

    // a mode change while stable must leave the flag up one edge later;
    // the flag is looked at after the change, so a broken clear would show
    sequence seq_mode_change_stable;
        reference_stable_flag && reference_enable && $changed(buffer_mode_select);
    endsequence
    sequence seq_flag_kept;
        reference_stable_flag;
    endsequence
    AST_MODE_KEEPS_STABLE: assert property (@(posedge aclk) disable iff (!aresetn) // [R20]
        seq_mode_change_stable |=> seq_flag_kept)
        else $error("mode change cleared stable flag");

    AST_TRIM_LOAD: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
        $rose(trim_loaded) |-> reference_trim == $past(factory_trim))
        else $error("trim not loaded from factory value");
    AST_RESERVED_ZERO: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
        (rvalid && $rose(rvalid) && $past(araddr) == `VR_CTRL_ADDR) |-> rdata[4:3] == 2'b00)
        else $error("reserved bits read nonzero");
    AST_WRITE_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn) // [R21]
        (do_write && wr_addr == `VR_CTRL_ADDR && wr_strb[0]) |=> reference_enable == $past(wr_data[7]))
        else $error("control write did not take effect");
    AST_REG_GATED: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
        ##1 analog_ctrl.regulator_enable == $past(reference_enable && regulator_enable))
        else $error("regulator enable mismatch");

    // disabling the reference switches the bandgap, regulator and compensation enables and the pin off
    sequence seq_disabled;
        !reference_enable;
    endsequence
    sequence seq_all_off;
        !analog_ctrl.bandgap_enable && !analog_ctrl.regulator_enable &&
            !analog_ctrl.curvature_comp_enable && !ref_out_oe;
    endsequence
    AST_DISABLED_ALL_OFF: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
        seq_disabled |=> seq_all_off)
        else $error("analog enables left on while disabled");

    // startup takes time: the flag stays low for two edges after enable is seen;
    // this presumes a startup count of at least two cycles
    sequence seq_enable_from_off;
        startup_state == ST_OFF && reference_enable;
    endsequence
    sequence seq_not_yet_stable;
        !reference_stable_flag;
    endsequence
    AST_NO_INSTANT_STABLE: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
        seq_enable_from_off |=> seq_not_yet_stable ##1 seq_not_yet_stable)
        else $error("stable flag rose without startup time");
    AST_STABLE_RISE_NEEDS_EN: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
        $rose(reference_stable_flag) |-> $past(reference_enable))
        else $error("stable flag rose while disabled");

    // only one buffer may be on at a time, and the trim code reaches the analog side
    AST_BUFFERS_EXCLUSIVE: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
        !(analog_ctrl.high_power_buffer_enable && analog_ctrl.low_power_buffer_enable))
        else $error("both buffers enabled");
    AST_TRIM_CODE: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
        ##1 analog_ctrl.trim_code == $past(reference_trim[5:0]))
        else $error("trim code not driven");

endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking testbench for the voltage reference control block
`timescale 1ns/10ps
`default_nettype none
`include "voltage_reference_params.svh"

module testbench
    import voltage_reference_pkg::*;
;
    // ==========================================================
    // signals and scoreboard
    // ==========================================================
    localparam int STARTUP = 4; // short startup count keeps the run brief
    logic aclk, aresetn;
    logic [7:0] factory_trim;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [5:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    analog_ctrl_t analog_ctrl;
    logic ref_out_oe;
    int bad_count, checks_done;
    logic [33:0] exp_r[$]; // expected {rresp, rdata}
    logic [1:0] exp_b[$]; // expected bresp
    logic [7:0] trim_m, ctrl_m; // model of register contents, stable bit kept apart
    logic [7:0] v;

    voltage_reference_control #(.STARTUP_CYCLES(STARTUP)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .factory_trim(factory_trim),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .analog_ctrl(analog_ctrl), .ref_out_oe(ref_out_oe));

    // free-running 20 mhz clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // ==========================================================
    // compare and report
    // ==========================================================
    task automatic cmp_read(input string nm, input logic [33:0] e, input logic [33:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_out(input string nm, input logic [12:0] e, input logic [12:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // a wait that ran out of cycles ends the run as a failure
    task automatic timed_out();
        bad_count++;
        $display("wrong value handshake expected answer seen none");
        wrap_up();
    endtask

    // response watcher: oldest note is taken off whenever an answer is accepted
    always @(posedge aclk) begin
        if (aresetn && bvalid && bready)
            cmp_resp("bresp", exp_b.size() ? exp_b.pop_front() : 2'bxx, bresp);
        if (aresetn && rvalid && rready)
            cmp_read("read word", exp_r.size() ? exp_r.pop_front() : 34'hx, {rresp, rdata});
    end

    // ==========================================================
    // bus tasks, entered just after a rising edge
    // ==========================================================
    function automatic logic [33:0] rd(input logic [1:0] r, input logic [7:0] d);
        return {r, 24'h00_0000, d};
    endfunction
    function automatic logic [33:0] rd_ctrl(input logic st);
        return rd(`VR_RESP_OKAY, {ctrl_m[7:5], 2'b00, st, ctrl_m[1:0]});
    endfunction
    // address and data offered together, each dropped once taken
    task automatic axi_write(input logic [5:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] e);
        int n;
        exp_b.push_back(e);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
        end
        bready <= 1'b0;
        if (n == 100) timed_out();
    endtask
    task automatic axi_read(input logic [5:0] a, input logic [33:0] e);
        int n;
        exp_r.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
        end
        rready <= 1'b0;
        if (n == 100) timed_out();
    endtask
    // analog enables and pin enable follow the register model
    task automatic check_outputs();
        analog_ctrl_t e;
        logic en;
        repeat (2) @(posedge aclk);
        en = ctrl_m[7];
        e.bandgap_enable = en;
        e.regulator_enable = en & ctrl_m[6];
        e.curvature_comp_enable = en & ctrl_m[5];
        e.chop_oscillator_enable = trim_m[6];
        e.high_power_buffer_enable = en && ctrl_m[1:0] == 2'b01;
        e.low_power_buffer_enable = en && ctrl_m[1:0] == 2'b10;
        e.trim_code = trim_m[5:0];
        cmp_out("analog outputs", {e, e.high_power_buffer_enable | e.low_power_buffer_enable},
            {analog_ctrl, ref_out_oe});
    endtask
    // synchronous reset for three edges with a fresh factory value
    task automatic do_reset();
        aresetn <= 1'b0;
        factory_trim <= 8'($urandom);
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        trim_m = factory_trim;
        ctrl_m = 8'h00;
        repeat (2) @(posedge aclk);
    endtask

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        aresetn = 1'b0;
        factory_trim = 8'h00;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 6'h00;
        araddr = 6'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'h0;
        bad_count = 0;
        checks_done = 0;
        void'($urandom(57869));
        do_reset();
        axi_read(`VR_TRIM_ADDR, rd(`VR_RESP_OKAY, trim_m));
        axi_read(`VR_CTRL_ADDR, rd_ctrl(1'b0));
        check_outputs();
        // trim code boundaries and chop bit, reserved bit 7 included
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            if (i == 0) v[5:0] = 6'h00;
            if (i == 1) v[5:0] = 6'h3f;
            if (i == 2) v[`VR_TRIM_CHOP_BIT] = 1'b1;
            if (i == 3) v[`VR_TRIM_CHOP_BIT] = 1'b0;
            axi_write(`VR_TRIM_ADDR, v, 4'hf, `VR_RESP_OKAY);
            trim_m = v;
            axi_read(`VR_TRIM_ADDR, rd(`VR_RESP_OKAY, v));
            check_outputs();
        end
        // enable with read-only bits written high, regulator off while unchopped, reserved mode
        axi_write(`VR_CTRL_ADDR, 8'hbf, 4'h1, `VR_RESP_OKAY);
        ctrl_m = 8'ha3;
        check_outputs();
        repeat (STARTUP + 10) @(posedge aclk);
        // every buffer mode while enabled and stable
        for (int m = 0; m < 4; m++) begin
            v = {1'b1, 1'b0, 1'($urandom), 3'b111, 2'(m)};
            axi_write(`VR_CTRL_ADDR, v, 4'h1, `VR_RESP_OKAY);
            ctrl_m = v & 8'he3;
            axi_read(`VR_CTRL_ADDR, rd_ctrl(1'b1));
            check_outputs();
        end
        // byte strobe low leaves the register alone
        axi_write(`VR_CTRL_ADDR, 8'h00, 4'h0, `VR_RESP_OKAY);
        axi_read(`VR_CTRL_ADDR, rd_ctrl(1'b1));
        // holes in the map refuse and change nothing
        axi_write(6'h08, 8'h00, 4'hf, `VR_RESP_SLVERR);
        axi_read(6'h3c, rd(`VR_RESP_SLVERR, 8'h00));
        axi_read(`VR_CTRL_ADDR, rd_ctrl(1'b1));
        // disabling drops stable flag and buffer even with a buffer mode chosen
        axi_write(`VR_CTRL_ADDR, 8'h21, 4'h1, `VR_RESP_OKAY);
        ctrl_m = 8'h21;
        axi_read(`VR_CTRL_ADDR, rd_ctrl(1'b0));
        check_outputs();
        // regulator bring-up: chop on, control with regulator off, settle, then regulator on
        axi_write(`VR_TRIM_ADDR, {trim_m[7], 1'b1, trim_m[5:0]}, 4'h1, `VR_RESP_OKAY);
        trim_m[`VR_TRIM_CHOP_BIT] = 1'b1;
        axi_write(`VR_CTRL_ADDR, 8'ha1, 4'h1, `VR_RESP_OKAY);
        ctrl_m = 8'ha1;
        repeat (`VR_REG_SETTLE_CYCLES) @(posedge aclk);
        axi_write(`VR_CTRL_ADDR, 8'he1, 4'h1, `VR_RESP_OKAY);
        ctrl_m = 8'he1;
        check_outputs();
        // reset in mid-run restores defaults and reloads the factory value
        do_reset();
        axi_read(`VR_CTRL_ADDR, rd_ctrl(1'b0));
        axi_read(`VR_TRIM_ADDR, rd(`VR_RESP_OKAY, trim_m));
        check_outputs();
        repeat (3) @(posedge aclk);
        wrap_up();
    end
endmodule
`default_nettype wire
